// ### rpiq_pkg.sv
package rpiq_pkg;

  // Register byte offsets
  localparam logic [11:0] ERR_QUEUE_OFF   = 12'h154;
  localparam logic [11:0] IRQ_HEADER_OFF  = 12'h158;
  localparam logic [11:0] IRQ_PAYLOAD_OFF = 12'h15c;
  localparam logic [11:0] LEG_STATUS_OFF  = 12'h160;
  localparam logic [11:0] LEG_MASK_OFF    = 12'h164;
  localparam logic [11:0] ERR_INJECT_OFF  = 12'h168;
  localparam logic [11:0] MSI_STAT_LO_OFF = 12'h170;
  localparam logic [11:0] MSI_STAT_HI_OFF = 12'h174;
  localparam logic [11:0] MSI_MASK_LO_OFF = 12'h178;
  localparam logic [11:0] MSI_MASK_HI_OFF = 12'h17c;
  localparam logic [11:0] RP_STATUS_OFF   = 12'h148;
  localparam logic [11:0] MSI_BASE_OFF    = 12'h150;

  // Field positions
  localparam int IQ_VALID_BIT  = 31;
  localparam int IQ_MSI_BIT    = 30;
  localparam int IQ_ASSERT_BIT = 29;
  localparam int IQ_LINE_LSB   = 27;
  localparam int IQ_ADDR_LSB   = 16;
  localparam int EQ_VALID_BIT  = 18;
  localparam int EQ_TYPE_LSB   = 16;
  localparam int LEG_LSB       = 16;
  localparam int RP_EQ_NE_BIT  = 16;
  localparam int RP_EQ_OVF_BIT = 17;
  localparam int RP_IQ_NE_BIT  = 18;
  localparam int RP_IQ_OVF_BIT = 19;
  localparam int INJ_UNCORR_BIT = 0;
  localparam int INJ_CORR_BIT   = 1;
  localparam int MSI_WIN_LSB    = 12;

  // Queue depths
  localparam int IQ_DEPTH = 8;
  localparam int EQ_DEPTH = 4;

  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage : rpiq_pkg

// ### rpiq_top.sv
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module rpiq_top (
  input  wire logic        i_clock,
  input  wire logic        i_sys_rst,
  input  wire logic        i_root_port,
  // INTx message in
  input  wire logic        i_intx_valid,
  input  wire logic [15:0] i_intx_req_id,
  input  wire logic [1:0]  i_intx_line,
  input  wire logic        i_intx_assert,
  // Memory write request in
  input  wire logic        i_memwr_valid,
  input  wire logic [15:0] i_memwr_req_id,
  input  wire logic [31:0] i_memwr_addr,
  input  wire logic [15:0] i_memwr_data,
  // Error message in
  input  wire logic        i_errmsg_valid,
  input  wire logic [15:0] i_errmsg_req_id,
  input  wire logic [1:0]  i_errmsg_class,
  // Outputs
  output logic             o_memwr_is_msi,
  output logic             o_interrupt_out,
  output logic [31:0]      o_msi_low_vector_output,
  output logic [31:0]      o_msi_high_vector_output,
  output logic             o_aer_uncorr_internal,
  output logic             o_aer_corr_internal,
  // AXI4-Lite slave
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  import rpiq_pkg::*;

  // Entry width: valid-less header (31 bits) plus 16-bit payload
  localparam int IQ_W = 47;

  // Increment a small pointer with wrap
  function automatic logic [2:0] ptr_inc(input logic [2:0] p, input logic [2:0] last);
    ptr_inc = (p == last) ? 3'h0 : p + 3'h1;
  endfunction : ptr_inc

  // Register address match on bits 11:2, used for both write and read addresses
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a[11:2] == off[11:2]);
  endfunction : hit

  logic [IQ_W-1:0] iq_mem_q [IQ_DEPTH];
  logic [2:0]      iq_wr_q, iq_rd_q;
  logic [3:0]      iq_cnt_q;
  logic [17:0]     eq_mem_q [EQ_DEPTH];
  logic [2:0]      eq_wr_q, eq_rd_q;
  logic [2:0]      eq_cnt_q;
  logic            iq_ovf_q, eq_ovf_q;
  logic [3:0]      leg_stat_q, leg_mask_q;
  logic [31:0]     msi_lo_q, msi_hi_q, mask_lo_q, mask_hi_q;
  logic [1:0]      inject_q;
  logic [31:0]     msi_base_q;
  logic [11:0]     awaddr_q, araddr_q;
  logic [31:0]     wdata_q;
  logic            aw_have_q, w_have_q;
  logic [31:0]     rdata_q;

  // Write and read channel bookkeeping
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  wire wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;
  wire rd_take = s_axi_arvalid & s_axi_arready;
  assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_have_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  // Register write decodes
  wire wr_iq_pop  = wr_fire & (hit(awaddr_q, IRQ_HEADER_OFF) | hit(awaddr_q, IRQ_PAYLOAD_OFF));
  wire wr_eq_pop  = wr_fire & hit(awaddr_q, ERR_QUEUE_OFF);
  wire wr_lmask   = wr_fire & hit(awaddr_q, LEG_MASK_OFF);
  wire wr_inject  = wr_fire & hit(awaddr_q, ERR_INJECT_OFF);
  wire wr_mstlo   = wr_fire & hit(awaddr_q, MSI_STAT_LO_OFF);
  wire wr_msthi   = wr_fire & hit(awaddr_q, MSI_STAT_HI_OFF);
  wire wr_mmlo    = wr_fire & hit(awaddr_q, MSI_MASK_LO_OFF);
  wire wr_mmhi    = wr_fire & hit(awaddr_q, MSI_MASK_HI_OFF);
  wire wr_rpstat  = wr_fire & hit(awaddr_q, RP_STATUS_OFF);
  wire wr_base    = wr_fire & hit(awaddr_q, MSI_BASE_OFF);
  wire wr_mapped  = wr_iq_pop | wr_eq_pop | wr_lmask | wr_inject | wr_mstlo | wr_msthi
                  | wr_mmlo | wr_mmhi | wr_rpstat | wr_base
                  | (wr_fire & hit(awaddr_q, LEG_STATUS_OFF));

  // MSI window match on incoming memory writes
  wire msi_hit = i_memwr_valid & i_root_port
               & (i_memwr_addr[31:MSI_WIN_LSB] == msi_base_q[31:MSI_WIN_LSB]);
  assign o_memwr_is_msi = msi_hit;
  wire [5:0] msi_vec = i_memwr_data[5:0];

  // Interrupt queue push (INTx wins the cycle, a simultaneous MSI is not queued)
  wire        iq_in_v  = (i_intx_valid & i_root_port) | msi_hit;
  wire        iq_full  = (iq_cnt_q == 4'(IQ_DEPTH));
  wire        iq_empty = (iq_cnt_q == 4'h0);
  wire        iq_pop   = wr_iq_pop & ~iq_empty;
  wire        iq_push  = iq_in_v & (~iq_full | iq_pop);
  wire        iq_drop  = iq_in_v & iq_full & ~iq_pop;
  // Header fields: MSI forces line and assert to zero
  wire [IQ_W-1:0] iq_in_entry = (i_intx_valid & i_root_port)
    ? {1'b0, i_intx_assert, i_intx_line, 11'h000, i_intx_req_id, 16'h0000}
    : {1'b1, 1'b0, 2'h0, i_memwr_addr[12:2], i_memwr_req_id, i_memwr_data};

  // Interrupt queue storage and pointers
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      iq_wr_q  <= 3'h0;
      iq_rd_q  <= 3'h0;
      iq_cnt_q <= 4'h0;
    end else begin
      if (iq_push) begin
        iq_mem_q[iq_wr_q] <= iq_in_entry;
        iq_wr_q <= ptr_inc(iq_wr_q, 3'(IQ_DEPTH - 1));
      end
      if (iq_pop) iq_rd_q <= ptr_inc(iq_rd_q, 3'(IQ_DEPTH - 1));
      iq_cnt_q <= iq_cnt_q + 4'(iq_push) - 4'(iq_pop);
    end
  end

  // Error queue
  wire eq_in_v  = i_errmsg_valid & i_root_port;
  wire eq_full  = (eq_cnt_q == 3'(EQ_DEPTH));
  wire eq_empty = (eq_cnt_q == 3'h0);
  wire eq_pop   = wr_eq_pop & ~eq_empty;
  wire eq_push  = eq_in_v & (~eq_full | eq_pop);
  wire eq_drop  = eq_in_v & eq_full & ~eq_pop;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      eq_wr_q  <= 3'h0;
      eq_rd_q  <= 3'h0;
      eq_cnt_q <= 3'h0;
    end else begin
      if (eq_push) begin
        eq_mem_q[eq_wr_q[1:0]] <= {i_errmsg_class, i_errmsg_req_id};
        eq_wr_q <= ptr_inc(eq_wr_q, 3'(EQ_DEPTH - 1));
      end
      if (eq_pop) eq_rd_q <= ptr_inc(eq_rd_q, 3'(EQ_DEPTH - 1));
      eq_cnt_q <= eq_cnt_q + 3'(eq_push) - 3'(eq_pop);
    end
  end

  // Sticky overflow flags, set beats clear
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      iq_ovf_q <= 1'b0;
      eq_ovf_q <= 1'b0;
    end else begin
      iq_ovf_q <= iq_drop | (iq_ovf_q & ~(wr_rpstat & wdata_q[RP_IQ_OVF_BIT]));
      eq_ovf_q <= eq_drop | (eq_ovf_q & ~(wr_rpstat & wdata_q[RP_EQ_OVF_BIT]));
    end
  end

  // Legacy line status from assert/deassert messages
  wire [3:0] line_sel = 4'h1 << i_intx_line;
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) leg_stat_q <= 4'h0;
    else if (i_intx_valid & i_root_port) begin
      if (i_intx_assert) leg_stat_q <= leg_stat_q | line_sel;
      else leg_stat_q <= leg_stat_q & ~line_sel;
    end
  end

  // MSI vector status: incoming set wins over write-one clear
  wire [31:0] msi_set_lo = (msi_hit & ~msi_vec[5]) ? (32'h1 << msi_vec[4:0]) : 32'h0;
  wire [31:0] msi_set_hi = (msi_hit &  msi_vec[5]) ? (32'h1 << msi_vec[4:0]) : 32'h0;
  wire [31:0] clr_lo = wr_mstlo ? wdata_q : 32'h0;
  wire [31:0] clr_hi = wr_msthi ? wdata_q : 32'h0;
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      msi_lo_q <= REG_RESET;
      msi_hi_q <= REG_RESET;
    end else begin
      msi_lo_q <= msi_set_lo | (msi_lo_q & ~clr_lo);
      msi_hi_q <= msi_set_hi | (msi_hi_q & ~clr_hi);
    end
  end

  // Plain control registers and one-cycle injection pulses
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      leg_mask_q <= 4'h0;
      mask_lo_q  <= REG_RESET;
      mask_hi_q  <= REG_RESET;
      msi_base_q <= REG_RESET;
      inject_q   <= 2'h0;
    end else begin
      if (wr_lmask) leg_mask_q <= wdata_q[LEG_LSB +: 4];
      if (wr_mmlo) mask_lo_q <= wdata_q;
      if (wr_mmhi) mask_hi_q <= wdata_q;
      if (wr_base) msi_base_q <= {wdata_q[31:MSI_WIN_LSB], 12'h000};
      inject_q <= wr_inject ? wdata_q[1:0] : 2'h0;
    end
  end
  assign o_aer_uncorr_internal = inject_q[INJ_UNCORR_BIT];
  assign o_aer_corr_internal   = inject_q[INJ_CORR_BIT];

  // Decode-mode outputs through masks
  assign o_interrupt_out          = |(leg_stat_q & leg_mask_q);
  assign o_msi_low_vector_output  = msi_lo_q & mask_lo_q;
  assign o_msi_high_vector_output = msi_hi_q & mask_hi_q;

  // Read words; empty queues read zero apart from valid
  wire [IQ_W-1:0] iq_head = iq_empty ? '0 : iq_mem_q[iq_rd_q];
  wire [17:0]     eq_head = eq_empty ? '0 : eq_mem_q[eq_rd_q[1:0]];
  wire [31:0] iq_word1 = {~iq_empty, iq_head[46:16]};
  wire [31:0] iq_word2 = {16'h0000, iq_head[15:0]};
  wire [31:0] eq_word  = {13'h0, ~eq_empty, eq_head};
  wire [31:0] rp_word  = {12'h0, iq_ovf_q, ~iq_empty, eq_ovf_q, ~eq_empty, 16'h0};
  wire [31:0] rd_mux =
      hit(s_axi_araddr, IRQ_HEADER_OFF)  ? iq_word1 :
      hit(s_axi_araddr, IRQ_PAYLOAD_OFF) ? iq_word2 :
      hit(s_axi_araddr, ERR_QUEUE_OFF)   ? eq_word :
      hit(s_axi_araddr, RP_STATUS_OFF)   ? rp_word :
      hit(s_axi_araddr, MSI_BASE_OFF)    ? msi_base_q :
      hit(s_axi_araddr, LEG_STATUS_OFF)  ? {12'h0, leg_stat_q, 16'h0} :
      hit(s_axi_araddr, LEG_MASK_OFF)    ? {12'h0, leg_mask_q, 16'h0} :
      hit(s_axi_araddr, ERR_INJECT_OFF)  ? {30'h0, inject_q} :
      hit(s_axi_araddr, MSI_STAT_LO_OFF) ? msi_lo_q :
      hit(s_axi_araddr, MSI_STAT_HI_OFF) ? msi_hi_q :
      hit(s_axi_araddr, MSI_MASK_LO_OFF) ? mask_lo_q :
      hit(s_axi_araddr, MSI_MASK_HI_OFF) ? mask_hi_q : 32'h0;
  wire rd_mapped = (s_axi_araddr >= RP_STATUS_OFF) & (s_axi_araddr <= MSI_MASK_HI_OFF)
                 & ~hit(s_axi_araddr, 12'h16c);

  // AXI4-Lite handshakes
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      aw_have_q    <= 1'b0;
      w_have_q     <= 1'b0;
      awaddr_q     <= 12'h000;
      wdata_q      <= REG_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= RESP_OKAY;
      rdata_q      <= REG_RESET;
    end else begin
      if (aw_take) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (w_take) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
      end
      if (wr_fire) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        rdata_q      <= i_root_port ? rd_mux : 32'h0;
      end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_rdata = rdata_q;

  // Checks
  property p_inject_pulse;
    @(posedge i_clock) disable iff (i_sys_rst)
      o_aer_uncorr_internal |=> !o_aer_uncorr_internal || $past(wr_inject);
  endproperty
  a_inject_pulse: assert property (p_inject_pulse) else $error("inject stuck");

  property p_valid_bit;
    @(posedge i_clock) disable iff (i_sys_rst)
      rd_take && i_root_port && hit(s_axi_araddr, IRQ_HEADER_OFF)
        |=> s_axi_rdata[IQ_VALID_BIT] == ($past(iq_cnt_q) != 4'h0);
  endproperty
  a_valid_bit: assert property (p_valid_bit) else $error("valid bit wrong");

  property p_not_rp;
    @(posedge i_clock) disable iff (i_sys_rst)
      rd_take && !i_root_port |=> s_axi_rdata == 32'h0;
  endproperty
  a_not_rp: assert property (p_not_rp) else $error("non root read nonzero");

  property p_empty_pop;
    @(posedge i_clock) disable iff (i_sys_rst)
      iq_empty && wr_iq_pop && !iq_in_v |=> iq_empty;
  endproperty
  a_empty_pop: assert property (p_empty_pop) else $error("empty pop changed queue");

  property p_overflow;
    @(posedge i_clock) disable iff (i_sys_rst)
      iq_drop |=> iq_ovf_q && $stable(iq_cnt_q);
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow not flagged");

  property p_msi_out;
    @(posedge i_clock) disable iff (i_sys_rst)
      msi_hit && !msi_vec[5] && mask_lo_q[msi_vec[4:0]]
        |=> o_msi_low_vector_output[$past(msi_vec[4:0])];
  endproperty
  a_msi_out: assert property (p_msi_out) else $error("msi vector not shown");

  property p_read_keeps;
    @(posedge i_clock) disable iff (i_sys_rst)
      rd_take && !wr_iq_pop && !iq_in_v |=> $stable(iq_cnt_q);
  endproperty
  a_read_keeps: assert property (p_read_keeps) else $error("read removed entry");

  property p_leg_assert;
    @(posedge i_clock) disable iff (i_sys_rst)
      i_intx_valid && i_root_port && i_intx_assert |=> leg_stat_q[$past(i_intx_line)];
  endproperty
  a_leg_assert: assert property (p_leg_assert) else $error("line status not set");

endmodule : rpiq_top

`default_nettype wire

// ### rpiq_msg_source.sv
`timescale 1ns/1ps
`default_nettype none

// Downstream devices: each call puts one message pulse on the lines
module rpiq_msg_source (
  input  wire logic        i_clock,
  output logic             o_intx_valid,
  output logic [15:0]      o_intx_req_id,
  output logic [1:0]       o_intx_line,
  output logic             o_intx_assert,
  output logic             o_memwr_valid,
  output logic [15:0]      o_memwr_req_id,
  output logic [31:0]      o_memwr_addr,
  output logic [15:0]      o_memwr_data,
  output logic             o_errmsg_valid,
  output logic [15:0]      o_errmsg_req_id,
  output logic [1:0]       o_errmsg_class
);
  // Idle lines at time zero
  initial begin
    {o_intx_valid, o_intx_req_id, o_intx_line, o_intx_assert} = '0;
    {o_memwr_valid, o_memwr_req_id, o_memwr_addr, o_memwr_data} = '0;
    {o_errmsg_valid, o_errmsg_req_id, o_errmsg_class} = '0;
  end

  // Payload shows its inverse once the pulse is over
  task automatic send_intx(input logic [15:0] id, input logic [1:0] ln, input logic asrt);
    @(posedge i_clock);
    {o_intx_valid, o_intx_req_id, o_intx_line, o_intx_assert} <= {1'b1, id, ln, asrt};
    @(posedge i_clock);
    {o_intx_valid, o_intx_req_id, o_intx_line, o_intx_assert} <= {1'b0, ~id, ~ln, ~asrt};
  endtask : send_intx

  task automatic send_memwr(input logic [15:0] id, input logic [31:0] a, input logic [15:0] d);
    @(posedge i_clock);
    {o_memwr_valid, o_memwr_req_id, o_memwr_addr, o_memwr_data} <= {1'b1, id, a, d};
    @(posedge i_clock);
    {o_memwr_valid, o_memwr_req_id, o_memwr_addr, o_memwr_data} <= {1'b0, ~id, ~a, ~d};
  endtask : send_memwr

  task automatic send_err(input logic [15:0] id, input logic [1:0] cls);
    @(posedge i_clock);
    {o_errmsg_valid, o_errmsg_req_id, o_errmsg_class} <= {1'b1, id, cls};
    @(posedge i_clock);
    {o_errmsg_valid, o_errmsg_req_id, o_errmsg_class} <= {1'b0, ~id, ~cls};
  endtask : send_err
endmodule : rpiq_msg_source

`default_nettype wire

// ### rpiq_tb.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import rpiq_pkg::*;
  logic        clock = 0, rst = 1, root = 1, awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0, last_msi = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, ma, msi_lo, msi_hi;
  logic        awready, wready, bvalid, arready, rvalid, is_msi, irq_out, unc, cor;
  logic        iv, ia, mv, ev;
  logic [15:0] iid, mid, md, eid;
  logic [1:0]  il, ec, bresp, rresp;
  int          errors = 0, n_compared = 0, n_unc = 0, n_cor = 0;

  initial forever #10 clock = ~clock;
  // Pulse counters and window flag, sampled mid-cycle
  always @(negedge clock) begin
    if (unc === 1'b1) n_unc++;
    if (cor === 1'b1) n_cor++;
    if (mv === 1'b1) last_msi = is_msi;
  end

  rpiq_msg_source src (.i_clock(clock), .o_intx_valid(iv), .o_intx_req_id(iid),
    .o_intx_line(il), .o_intx_assert(ia), .o_memwr_valid(mv), .o_memwr_req_id(mid),
    .o_memwr_addr(ma), .o_memwr_data(md), .o_errmsg_valid(ev), .o_errmsg_req_id(eid),
    .o_errmsg_class(ec));
  rpiq_top dut (.i_clock(clock), .i_sys_rst(rst), .i_root_port(root), .i_intx_valid(iv),
    .i_intx_req_id(iid), .i_intx_line(il), .i_intx_assert(ia), .i_memwr_valid(mv),
    .i_memwr_req_id(mid), .i_memwr_addr(ma), .i_memwr_data(md), .i_errmsg_valid(ev),
    .i_errmsg_req_id(eid), .i_errmsg_class(ec), .o_memwr_is_msi(is_msi),
    .o_interrupt_out(irq_out), .o_msi_low_vector_output(msi_lo),
    .o_msi_high_vector_output(msi_hi), .o_aer_uncorr_internal(unc),
    .o_aer_corr_internal(cor), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  task automatic close_out;
    if (errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // A wait that ran out ends the run
  task automatic tmo(input int n);
    if (n >= 64) begin
      errors++;
      close_out();
    end
  endtask : tmo

  // Write: address and data offered together, each released once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    int n;
    logic pa, pw, ta, tw;
    n = 0;
    pa = 1;
    pw = 1;
    @(posedge clock);
    {awaddr, awvalid, wdata, wvalid, bready} <= {a, 1'b1, d, 1'b1, 1'b1};
    while ((pa || pw) && n < 64) begin
      @(negedge clock);
      ta = pa && awready === 1'b1;
      tw = pw && wready === 1'b1;
      @(posedge clock);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
      n++;
    end
    @(negedge clock);
    while (bvalid !== 1'b1 && n < 64) begin
      @(negedge clock);
      n++;
    end
    tmo(n);
    chk({30'h0, bresp}, {30'h0, er});
    @(posedge clock);
    bready <= 1'b0;
  endtask : wr

  // Read and compare data and response
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
    int n;
    n = 0;
    @(posedge clock);
    {araddr, arvalid, rready} <= {a, 1'b1, 1'b1};
    @(negedge clock);
    while (arready !== 1'b1 && n < 64) begin
      @(negedge clock);
      n++;
    end
    @(posedge clock);
    arvalid <= 1'b0;
    @(negedge clock);
    while (rvalid !== 1'b1 && n < 64) begin
      @(negedge clock);
      n++;
    end
    tmo(n);
    chk(rdata, e);
    chk({30'h0, rresp}, {30'h0, er});
    @(posedge clock);
    rready <= 1'b0;
  endtask : rd

  // Reset values, read-only status, unmapped place
  task automatic t_reset;
    logic [11:0] offs[10] = '{ERR_QUEUE_OFF, IRQ_HEADER_OFF, IRQ_PAYLOAD_OFF, LEG_STATUS_OFF,
      LEG_MASK_OFF, ERR_INJECT_OFF, MSI_STAT_LO_OFF, MSI_STAT_HI_OFF, MSI_MASK_LO_OFF,
      MSI_MASK_HI_OFF};
    foreach (offs[i]) rd(offs[i], REG_RESET);
    rd(12'h16c, 32'h0, RESP_SLVERR);
    wr(12'h16c, 32'hffff_ffff, RESP_SLVERR);
    wr(LEG_STATUS_OFF, 32'h000f_0000);
    rd(LEG_STATUS_OFF, 32'h0);
  endtask : t_reset

  // Every legacy line, read order header then payload, pops from both words
  task automatic t_intx;
    for (int l = 0; l < 4; l++) begin
      src.send_intx(16'h1230 + 16'(l), l[1:0], 1'b1);
      rd(IRQ_HEADER_OFF, {3'b101, l[1:0], 11'h0, 16'h1230 + 16'(l)});
      rd(IRQ_PAYLOAD_OFF, 32'h0);
      rd(IRQ_HEADER_OFF, {3'b101, l[1:0], 11'h0, 16'h1230 + 16'(l)});
      wr(l[0] ? IRQ_HEADER_OFF : IRQ_PAYLOAD_OFF, 32'h5a5a_0000 + 32'(l));
    end
    rd(LEG_STATUS_OFF, 32'h000f_0000);
    chk({31'h0, irq_out}, 32'h0);
    wr(LEG_MASK_OFF, 32'h0004_0000);
    chk({31'h0, irq_out}, 32'h1);
    src.send_intx(16'h0042, 2'h2, 1'b0);
    rd(LEG_STATUS_OFF, 32'h000b_0000);
    chk({31'h0, irq_out}, 32'h0);
    rd(IRQ_HEADER_OFF, 32'h9000_0042);
    wr(IRQ_HEADER_OFF, 32'h0);
    rd(IRQ_HEADER_OFF, 32'h0);
  endtask : t_intx

  // MSI window, header and payload, decode status, masks, write one to clear
  task automatic t_msi;
    wr(MSI_BASE_OFF, 32'h1000_0000);
    src.send_memwr(16'h00a5, 32'h1000_0abc, 16'h0025);
    chk({31'h0, last_msi}, 32'h1);
    rd(IRQ_HEADER_OFF, 32'hc2af_00a5);
    rd(IRQ_PAYLOAD_OFF, 32'h0000_0025);
    rd(MSI_STAT_HI_OFF, 32'h0000_0020);
    chk(msi_hi, 32'h0);
    wr(MSI_MASK_HI_OFF, 32'h0000_0020);
    chk(msi_hi, 32'h0000_0020);
    wr(MSI_STAT_HI_OFF, 32'hffff_ffdf);
    rd(MSI_STAT_HI_OFF, 32'h0000_0020);
    wr(IRQ_PAYLOAD_OFF, 32'h0);
    src.send_memwr(16'h0001, 32'h1000_0ffc, 16'h0003);
    rd(MSI_STAT_LO_OFF, 32'h0000_0008);
    wr(MSI_MASK_LO_OFF, 32'hffff_fff7);
    chk(msi_lo, 32'h0);
    wr(MSI_MASK_LO_OFF, 32'h0000_0008);
    chk(msi_lo, 32'h0000_0008);
    wr(MSI_STAT_LO_OFF, 32'h0000_0008);
    rd(MSI_STAT_LO_OFF, 32'h0);
    wr(IRQ_HEADER_OFF, 32'h0);
    src.send_memwr(16'h0002, 32'h1000_1000, 16'h0001);
    chk({31'h0, last_msi}, 32'h0);
    rd(IRQ_HEADER_OFF, 32'h0);
  endtask : t_msi

  // Overfill the queue, drain it, pop while empty, clear the overflow flag
  task automatic t_ovf;
    for (int i = 0; i <= IQ_DEPTH; i++) src.send_intx(16'(i), 2'h0, 1'b0);
    rd(RP_STATUS_OFF, 32'h000c_0000);
    for (int i = 0; i < IQ_DEPTH; i++) begin
      rd(IRQ_HEADER_OFF, 32'h8000_0000 + 32'(i));
      wr(IRQ_HEADER_OFF, 32'h0);
    end
    wr(IRQ_PAYLOAD_OFF, 32'h0);
    rd(RP_STATUS_OFF, 32'h0008_0000);
    src.send_intx(16'h0077, 2'h1, 1'b0);
    rd(IRQ_HEADER_OFF, 32'h8800_0077);
    wr(IRQ_HEADER_OFF, 32'h0);
    wr(RP_STATUS_OFF, 32'h0008_0000);
    rd(RP_STATUS_OFF, 32'h0);
  endtask : t_ovf

  // Every error class, non-destructive read, pop, pop while empty
  task automatic t_err;
    for (int c = 0; c < 4; c++) begin
      src.send_err(16'hbe00 + 16'(c), c[1:0]);
      rd(ERR_QUEUE_OFF, {13'h0, 1'b1, c[1:0], 16'hbe00 + 16'(c)});
      rd(ERR_QUEUE_OFF, {13'h0, 1'b1, c[1:0], 16'hbe00 + 16'(c)});
      wr(ERR_QUEUE_OFF, 32'hffff_ffff);
    end
    wr(ERR_QUEUE_OFF, 32'h0);
    src.send_err(16'h0123, 2'h2);
    rd(ERR_QUEUE_OFF, 32'h0006_0123);
    wr(ERR_QUEUE_OFF, 32'h0);
    rd(ERR_QUEUE_OFF, 32'h0);
  endtask : t_err

  // Each injection bit gives a single one-cycle report
  task automatic t_inject;
    for (int b = 0; b < 2; b++) begin
      n_unc = 0;
      n_cor = 0;
      wr(ERR_INJECT_OFF, 32'h1 << b);
      repeat (4) @(posedge clock);
      chk(32'(n_unc), 32'(b == 0));
      chk(32'(n_cor), 32'(b == 1));
      rd(ERR_INJECT_OFF, 32'h0);
    end
  endtask : t_inject

  // Not a root port: queue and decode words read zero
  task automatic t_nonroot;
    src.send_memwr(16'h0003, 32'h1000_0000, 16'h0003);
    @(posedge clock);
    root <= 1'b0;
    rd(IRQ_HEADER_OFF, 32'h0);
    rd(IRQ_PAYLOAD_OFF, 32'h0);
    rd(MSI_STAT_LO_OFF, 32'h0);
    rd(LEG_STATUS_OFF, 32'h0);
    @(posedge clock);
    root <= 1'b1;
    rd(MSI_STAT_LO_OFF, 32'h0000_0008);
  endtask : t_nonroot

  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_intx();
    t_msi();
    t_ovf();
    t_err();
    t_inject();
    t_nonroot();
    close_out();
  end
endmodule : testbench

`default_nettype wire
